// ===== design/clock_gen_map.vh
// register offsets, field positions, reset values and timing figures of the clock generator
`ifndef CLOCK_GEN_MAP_VH
`define CLOCK_GEN_MAP_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define OFS_CTRL        8'h00
`define OFS_TRIM        8'h04
`define OFS_STATUS      8'h08
`define OFS_CLKSEL      8'h0c
`define OFS_DCOWORD     8'h10

// ************************************************************
// field positions
// ************************************************************
`define CTRL_SRC_LSB    0
`define CTRL_REFSEL     2
`define CTRL_RDIV_LSB   3
`define CTRL_ODIV_LSB   6
`define CTRL_LOCKIE     9
`define CTRL_MONEN      10
`define CTRL_MONRST     11
`define STAT_LOCKED     0
`define STAT_LOCKCHG    1
`define STAT_CLKFAIL    2
`define STAT_SRC_LSB    3

// ************************************************************
// source encodings and reset values
// ************************************************************
`define SRC_FLL         2'b00
`define SRC_INT         2'b01
`define SRC_EXT         2'b10
`define SRC_BAD         2'b11
`define TRIM_RESET      9'h100
`define IRC_BASE_INC    24'h006666

// ************************************************************
// timing figures
// ************************************************************
`define CLK_MHZ         20
`define DCO_MIN_MHZ     32
`define DCO_MAX_MHZ     40
`define MON_TIMEOUT_US  100
`define FLL_STEP        16'h0010
`define LOCK_TOL        12'h004

`endif

// ===== design/clock_gen.v
// clock generator: loop, reference sources, dividers, consumer clock selection, apb registers
//
// Functional notes
// - bus clock from internal, external or loop
// - output divider by one to 128
// - reset selects loop engaged on internal reference
// - debug link clock is oscillator over two
// - debug clock runs in reference modes too
// - fixed rate is loop reference halved, synchronised
// - fixed rate selectable by all three timers
// - internal reference selectable by watchdog, counter
// - slow oscillator selectable by counter, watchdog
// - crystal output selectable by counter, watchdog, converter
// - lock detector can raise an interrupt
// - external clock monitor can request reset
// - internal reference trimmed by nine bits
// - external reference divided before the loop
// - loop locks to internal or external reference
// - loop reference output carries the loop reference
// - system clock equals bus clock
// - crystal feeds generator, counter and others
// - oscillator held within 32 to 40 MHz
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_map.vh"

module clock_gen #(
    parameter FLL_FACTOR = 1024,             // oscillator cycles per loop reference cycle
    parameter LOCK_REFS  = 4                 // in-range reference periods before lock
) (
    input  wire        pclk,                 // bus clock, 20 MHz
    input  wire        presetn,              // asynchronous reset, active low
    input  wire        psel,                 // apb select
    input  wire        penable,              // apb access phase
    input  wire        pwrite,               // apb direction
    input  wire [7:0]  paddr,                // apb byte address
    input  wire [31:0] pwdata,               // apb write data
    output reg  [31:0] prdata,               // apb read data
    output reg         pready,               // apb ready
    output reg         pslverr,              // apb error, unmapped address
    input  wire        crystal_tick,         // crystal oscillator unit output, one pulse per cycle
    input  wire        slow_osc_tick,        // low power 1 kHz oscillator pulse
    input  wire        timer_ext_clock_a,    // external timer clock a, level
    input  wire        timer_ext_clock_c,    // external timer clock c, level
    output reg         main_clock_out,       // divided main clock pulse
    output reg         system_bus_clock,     // system bus clock pulse
    output reg         debug_link_clock,     // oscillator over two pulse
    output reg         internal_ref_clock_out, // internal reference pulse
    output reg         loop_ref_clock,       // loop reference pulse
    output reg         fixed_rate_clock,     // fixed rate pulse
    output reg         slow_osc_clock,       // slow oscillator pulse
    output reg         crystal_clock_out,    // crystal pulse
    output reg         flexible_timer_clock_a, // counting clock of flexible timer a
    output reg         flexible_timer_clock_c, // counting clock of flexible timer c
    output reg         modulo_timer_clock,   // counting clock of modulo timer
    output reg         watchdog_clock,       // watchdog unit clock
    output reg         rtc_clock,            // real-time counter clock
    output reg         adc_clock,            // converter clock
    output reg         lock_irq,             // lock change interrupt, level
    output reg         clock_fail_reset      // reset request on external clock loss, level
);

    // ************************************************************
    // derived constants
    // ************************************************************
    localparam [31:0] DCO_MIN_RAW = (`DCO_MIN_MHZ * 65536) / (2 * `CLK_MHZ);
    localparam [31:0] DCO_MAX_RAW = (`DCO_MAX_MHZ * 65536) / (2 * `CLK_MHZ);
    localparam [15:0] DCO_MIN_W   = DCO_MIN_RAW[15:0];
    localparam [15:0] DCO_MAX_W   = (DCO_MAX_RAW > 32'd65535) ? 16'hffff : DCO_MAX_RAW[15:0];
    localparam [15:0] DCO_RST_W   = DCO_MIN_W;
    localparam [31:0] MON_CYC_RAW = `MON_TIMEOUT_US * `CLK_MHZ;
    localparam [11:0] MON_CYC     = MON_CYC_RAW[11:0];
    localparam [31:0] TGT_RAW     = FLL_FACTOR / 2;
    localparam [11:0] FLL_TGT     = TGT_RAW[11:0];
    localparam [31:0] LREF_RAW    = LOCK_REFS - 1;
    localparam [2:0]  LOCK_LAST   = LREF_RAW[2:0];
    // lock detector states
    localparam [2:0]  ST_HUNT     = 3'b001;
    localparam [2:0]  ST_CONFIRM  = 3'b010;
    localparam [2:0]  ST_LOCK     = 3'b100;

    // four-way consumer clock select
    function pick4;
        input [1:0] sel;
        input       a;
        input       b;
        input       c;
        input       d;
        begin
            if (sel == 2'b00) begin
                pick4 = a;
            end else if (sel == 2'b01) begin
                pick4 = b;
            end else if (sel == 2'b10) begin
                pick4 = c;
            end else begin
                pick4 = d;
            end
        end
    endfunction

    // register address decode
    function addr_hit;
        input [7:0] a;
        begin
            addr_hit = (a == `OFS_CTRL) || (a == `OFS_TRIM) || (a == `OFS_STATUS) ||
                       (a == `OFS_CLKSEL) || (a == `OFS_DCOWORD);
        end
    endfunction

    // ************************************************************
    // registers and state
    // ************************************************************
    reg  [1:0]  src_r;
    reg         ref_sel_r;
    reg  [2:0]  rdiv_r;
    reg  [2:0]  odiv_cfg_r;
    reg  [2:0]  odiv_act_r;
    reg         lock_ie_r;
    reg         mon_en_r;
    reg         mon_rst_r;
    reg  [8:0]  trim_r;
    reg  [10:0] clksel_r;
    reg         lock_chg_r;
    reg         clk_fail_r;
    reg  [23:0] irc_acc_r;
    reg  [15:0] dco_acc_r;
    reg  [15:0] dco_word_r;
    reg  [7:0]  rdiv_cnt_r;
    reg  [7:0]  odiv_cnt_r;
    reg  [11:0] fll_cnt_r;
    reg  [2:0]  lock_st_r;
    reg  [2:0]  good_r;
    reg  [11:0] mon_cnt_r;
    reg         ff_tog_r;
    reg         ff_pend_r;
    reg         ta_q_r;
    reg         tc_q_r;
    reg  [15:0] dco_word_nxt;
    reg  [2:0]  lock_st_nxt;
    reg  [2:0]  good_nxt;
    reg  [31:0] rd_nxt;
    reg         src_tick;

    wire        access   = psel & penable & pready;
    wire        wr_en    = access & pwrite & ~pslverr;
    wire        wr_ctrl  = wr_en & (paddr == `OFS_CTRL);
    wire        wr_trim  = wr_en & (paddr == `OFS_TRIM);
    wire        wr_stat  = wr_en & (paddr == `OFS_STATUS);
    wire        wr_csel  = wr_en & (paddr == `OFS_CLKSEL);

    // ************************************************************
    // reference sources and oscillator model
    // ************************************************************
    // trim moves the internal reference rate around its centre
    wire [23:0] irc_inc  = `IRC_BASE_INC - 24'h000100 + {15'h0000, trim_r};
    wire [24:0] irc_sum  = {1'b0, irc_acc_r} + {1'b0, irc_inc};
    wire        irc_tick = irc_sum[24];
    // accumulator carry stands for one half of the oscillator rate
    wire [16:0] dco_sum  = {1'b0, dco_acc_r} + {1'b0, dco_word_r};
    wire        dco_half = dco_sum[16];
    wire [7:0]  rdiv_top = (8'h01 << rdiv_r) - 8'h01;
    wire        ext_div_tick = crystal_tick & (rdiv_cnt_r == rdiv_top);
    wire        fll_ref  = ref_sel_r ? ext_div_tick : irc_tick;
    wire        ext_used = ref_sel_r | (src_r == `SRC_EXT);
    wire [7:0]  odiv_top = (8'h01 << odiv_act_r) - 8'h01;
    wire [11:0] fll_err  = (fll_cnt_r > FLL_TGT) ? fll_cnt_r - FLL_TGT : FLL_TGT - fll_cnt_r;
    wire        in_range = (fll_err <= `LOCK_TOL);
    wire        locked   = (lock_st_r == ST_LOCK);
    wire        mon_fail = mon_en_r & ext_used & (mon_cnt_r == MON_CYC);
    wire        ta_edge  = timer_ext_clock_a & ~ta_q_r;
    wire        tc_edge  = timer_ext_clock_c & ~tc_q_r;

    // main source select; the reserved code is never stored
    always @* begin
        case (src_r)
            `SRC_INT: src_tick = irc_tick;
            `SRC_EXT: src_tick = crystal_tick;
            default:  src_tick = dco_half;
        endcase
    end

    // ************************************************************
    // frequency-locked loop and lock detector
    // ************************************************************
    // step the oscillator word each reference period, clamped to its range
    always @* begin
        dco_word_nxt = dco_word_r;
        lock_st_nxt  = lock_st_r;
        good_nxt     = good_r;
        if (fll_ref) begin
            if (fll_cnt_r < FLL_TGT) begin
                dco_word_nxt = (dco_word_r > DCO_MAX_W - `FLL_STEP) ? DCO_MAX_W : dco_word_r + `FLL_STEP;
            end else if (fll_cnt_r > FLL_TGT) begin
                dco_word_nxt = (dco_word_r < DCO_MIN_W + `FLL_STEP) ? DCO_MIN_W : dco_word_r - `FLL_STEP;
            end
            case (lock_st_r)
                ST_HUNT: begin
                    good_nxt = 3'h0;
                    if (in_range) begin
                        lock_st_nxt = ST_CONFIRM;
                    end
                end
                ST_CONFIRM: begin
                    if (!in_range) begin
                        lock_st_nxt = ST_HUNT;
                    end else if (good_r >= LOCK_LAST - 3'h1 || LOCK_LAST == 3'h0) begin
                        lock_st_nxt = ST_LOCK;
                    end else begin
                        good_nxt = good_r + 3'h1;
                    end
                end
                default: begin
                    if (!in_range) begin
                        lock_st_nxt = ST_HUNT;
                    end
                end
            endcase
        end
    end

    // oscillator, reference counters and loop state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irc_acc_r  <= 24'h000000;
            dco_acc_r  <= 16'h0000;
            dco_word_r <= DCO_RST_W;
            rdiv_cnt_r <= 8'h00;
            fll_cnt_r  <= 12'h000;
            lock_st_r  <= ST_HUNT;
            good_r     <= 3'h0;
            mon_cnt_r  <= 12'h000;
        end else begin
            irc_acc_r  <= irc_sum[23:0];
            dco_acc_r  <= dco_sum[15:0];
            dco_word_r <= dco_word_nxt;
            lock_st_r  <= lock_st_nxt;
            good_r     <= good_nxt;
            if (crystal_tick) begin
                rdiv_cnt_r <= (rdiv_cnt_r >= rdiv_top) ? 8'h00 : rdiv_cnt_r + 8'h01;
            end
            // count oscillator half cycles per reference period
            if (fll_ref) begin
                fll_cnt_r <= {11'h000, dco_half};
            end else if (dco_half && fll_cnt_r != 12'hfff) begin
                fll_cnt_r <= fll_cnt_r + 12'h001;
            end
            // cycles since the last crystal edge, saturating at the timeout
            if (crystal_tick || !ext_used) begin
                mon_cnt_r <= 12'h000;
            end else if (mon_cnt_r != MON_CYC) begin
                mon_cnt_r <= mon_cnt_r + 12'h001;
            end
        end
    end

    // ************************************************************
    // output divider and derived clocks
    // ************************************************************
    // a new exponent is adopted only at the divider wrap, so no runt pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            odiv_cnt_r <= 8'h00;
            odiv_act_r <= 3'h0;
            ff_tog_r   <= 1'b0;
            ff_pend_r  <= 1'b0;
            ta_q_r     <= 1'b0;
            tc_q_r     <= 1'b0;
        end else begin
            if (src_tick) begin
                if (odiv_cnt_r >= odiv_top) begin
                    odiv_cnt_r <= 8'h00;
                    odiv_act_r <= odiv_cfg_r;
                end else begin
                    odiv_cnt_r <= odiv_cnt_r + 8'h01;
                end
            end
            if (fll_ref) begin
                ff_tog_r <= ~ff_tog_r;
            end
            // pending half-rate event waits for a bus clock; a new one wins over the drain
            ff_pend_r <= (ff_pend_r & ~main_clock_out) | (fll_ref & ~ff_tog_r);
            ta_q_r    <= timer_ext_clock_a;
            tc_q_r    <= timer_ext_clock_c;
        end
    end

    // every clock leaves as a registered one-cycle pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_clock_out         <= 1'b0;
            system_bus_clock       <= 1'b0;
            debug_link_clock       <= 1'b0;
            internal_ref_clock_out <= 1'b0;
            loop_ref_clock         <= 1'b0;
            fixed_rate_clock       <= 1'b0;
            slow_osc_clock         <= 1'b0;
            crystal_clock_out      <= 1'b0;
            flexible_timer_clock_a <= 1'b0;
            flexible_timer_clock_c <= 1'b0;
            modulo_timer_clock     <= 1'b0;
            watchdog_clock         <= 1'b0;
            rtc_clock              <= 1'b0;
            adc_clock              <= 1'b0;
            lock_irq               <= 1'b0;
            clock_fail_reset       <= 1'b0;
        end else begin
            main_clock_out         <= src_tick & (odiv_cnt_r >= odiv_top);
            system_bus_clock       <= src_tick & (odiv_cnt_r >= odiv_top);
            debug_link_clock       <= dco_half;
            internal_ref_clock_out <= irc_tick;
            loop_ref_clock         <= fll_ref;
            fixed_rate_clock       <= ff_pend_r & main_clock_out;
            slow_osc_clock         <= slow_osc_tick;
            crystal_clock_out      <= crystal_tick;
            flexible_timer_clock_a <= pick4(clksel_r[1:0], main_clock_out, fixed_rate_clock, ta_edge, 1'b0);
            modulo_timer_clock     <= pick4(clksel_r[3:2], main_clock_out, fixed_rate_clock, ta_edge, 1'b0);
            watchdog_clock         <= pick4(clksel_r[5:4], irc_tick, slow_osc_tick, crystal_tick, main_clock_out);
            rtc_clock              <= pick4(clksel_r[7:6], irc_tick, slow_osc_tick, crystal_tick, main_clock_out);
            adc_clock              <= clksel_r[8] ? crystal_tick : main_clock_out;
            flexible_timer_clock_c <= pick4(clksel_r[10:9], main_clock_out, fixed_rate_clock, tc_edge, 1'b0);
            lock_irq               <= lock_chg_r & lock_ie_r;
            clock_fail_reset       <= mon_fail & mon_rst_r;
        end
    end

    // ************************************************************
    // apb register file
    // ************************************************************
    // read value assembled in the setup phase
    always @* begin
        rd_nxt = 32'h00000000;
        if (paddr == `OFS_CTRL) begin
            rd_nxt[11:0] = {mon_rst_r, mon_en_r, lock_ie_r, odiv_cfg_r, rdiv_r, ref_sel_r, src_r};
        end else if (paddr == `OFS_TRIM) begin
            rd_nxt[8:0] = trim_r;
        end else if (paddr == `OFS_STATUS) begin
            rd_nxt[4:0] = {src_r, clk_fail_r, lock_chg_r, locked};
        end else if (paddr == `OFS_CLKSEL) begin
            rd_nxt[10:0] = clksel_r;
        end else if (paddr == `OFS_DCOWORD) begin
            rd_nxt[15:0] = dco_word_r;
        end
    end

    // one ready pulse per transfer, raised by the setup phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            pslverr <= ~addr_hit(paddr);
            prdata  <= pwrite ? 32'h00000000 : rd_nxt;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
    end

    // control writes; status flags set by hardware beat a same-cycle clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_r      <= `SRC_FLL;
            ref_sel_r  <= 1'b0;
            rdiv_r     <= 3'h0;
            odiv_cfg_r <= 3'h0;
            lock_ie_r  <= 1'b0;
            mon_en_r   <= 1'b0;
            mon_rst_r  <= 1'b0;
            trim_r     <= `TRIM_RESET;
            clksel_r   <= 11'h000;
            lock_chg_r <= 1'b0;
            clk_fail_r <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                // the reserved source code is ignored, the old source stays
                if (pwdata[`CTRL_SRC_LSB+1:`CTRL_SRC_LSB] != `SRC_BAD) begin
                    src_r <= pwdata[`CTRL_SRC_LSB+1:`CTRL_SRC_LSB];
                end
                ref_sel_r  <= pwdata[`CTRL_REFSEL];
                rdiv_r     <= pwdata[`CTRL_RDIV_LSB+2:`CTRL_RDIV_LSB];
                odiv_cfg_r <= pwdata[`CTRL_ODIV_LSB+2:`CTRL_ODIV_LSB];
                lock_ie_r  <= pwdata[`CTRL_LOCKIE];
                mon_en_r   <= pwdata[`CTRL_MONEN];
                mon_rst_r  <= pwdata[`CTRL_MONRST];
            end
            if (wr_trim) begin
                trim_r <= pwdata[8:0];
            end
            if (wr_csel) begin
                clksel_r <= pwdata[10:0];
            end
            lock_chg_r <= (lock_chg_r & ~(wr_stat & pwdata[`STAT_LOCKCHG])) |
                          (lock_st_nxt[2] ^ lock_st_r[2]);
            clk_fail_r <= (clk_fail_r & ~(wr_stat & pwdata[`STAT_CLKFAIL])) | mon_fail;
        end
    end

endmodule

`default_nettype wire

// ===== verif/clock_partner.sv
// far side model: crystal, slow oscillator and external timer clock sources
`timescale 1ns/1ps
`default_nettype none
module clock_partner (
    input  wire logic pclk,              // bus clock
    input  wire logic presetn,           // reset, active low
    input  wire logic stop,              // crystal halted while high
    output var  logic crystal_tick,      // one pulse per crystal period
    output var  logic slow_osc_tick,     // slow oscillator pulse
    output var  logic timer_ext_clock_a, // external timer clock a
    output var  logic timer_ext_clock_c  // external timer clock c
);
    logic [15:0] cnt_r;
    // free running count, every far side clock is derived from it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end
    // slow clock shortened to keep the run brief; ext clocks well inside the quarter limit
    assign crystal_tick      = !stop && cnt_r[1:0] == 2'h0;
    assign slow_osc_tick     = cnt_r[5:0] == 6'h00;
    assign timer_ext_clock_a = cnt_r[2];
    assign timer_ext_clock_c = cnt_r[3];
endmodule
`default_nettype wire

// ===== verif/clock_gen_monitor.sv
// concurrent checks on the clock generator ports
`timescale 1ns/1ps
`default_nettype none
module clock_gen_monitor (
    input wire logic        pclk,             // bus clock
    input wire logic        presetn,          // reset, active low
    input wire logic        psel,             // apb select
    input wire logic        penable,          // apb access
    input wire logic        pready,           // apb ready
    input wire logic        pslverr,          // apb error
    input wire logic [31:0] prdata,           // apb read data
    input wire logic        crystal_tick,     // crystal pulse
    input wire logic        slow_osc_tick,    // slow pulse
    input wire logic        main_clock_out,   // divided clock
    input wire logic        system_bus_clock, // bus clock pulse
    input wire logic        internal_ref_clock_out, // internal ref
    input wire logic        fixed_rate_clock, // fixed rate
    input wire logic        slow_osc_clock,   // slow out
    input wire logic        crystal_clock_out, // crystal out
    input wire logic        clock_fail_reset  // monitor reset request
);
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_bus_eq_main; system_bus_clock == main_clock_out; endproperty
    property p_ready_pulse; psel && !penable |=> pready ##1 !pready; endproperty
    property p_err_ready; pslverr |-> pready; endproperty
    property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
    property p_crystal_fwd; 1'b1 |=> crystal_clock_out == $past(crystal_tick); endproperty
    property p_slow_fwd; 1'b1 |=> slow_osc_clock == $past(slow_osc_tick); endproperty
    property p_fixed_after_main; fixed_rate_clock |-> $past(main_clock_out); endproperty
    property p_ref_sparse; internal_ref_clock_out |=> !internal_ref_clock_out [*8]; endproperty
    property p_fail_on_loss; $rose(clock_fail_reset) |-> !$past(crystal_tick); endproperty
    a_bus_eq_main: assert property (p_bus_eq_main) else $error("bus clock differs");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready not one cycle");
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    a_crystal_fwd: assert property (p_crystal_fwd) else $error("crystal out wrong");
    a_slow_fwd: assert property (p_slow_fwd) else $error("slow out wrong");
    a_fixed_after_main: assert property (p_fixed_after_main) else $error("fixed rate unsynced");
    a_ref_sparse: assert property (p_ref_sparse) else $error("internal ref too fast");
    a_fail_on_loss: assert property (p_fail_on_loss) else $error("fail with crystal");
    c_fixed: cover property (fixed_rate_clock);
    c_fail: cover property ($rose(clock_fail_reset));
    c_err: cover property (pslverr);
endmodule
bind clock_gen clock_gen_monitor u_clock_gen_monitor (.*);
`default_nettype wire

// ===== verif/system_clock_generation_test.sv
// self-checking bench: registers, output divider, consumer clocks, clock monitor
`timescale 1ns/1ps
`default_nettype none
module system_clock_generation_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stop, err_q;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic crystal_tick, slow_osc_tick, timer_ext_clock_a, timer_ext_clock_c;
    logic main_clock_out, system_bus_clock, internal_ref_clock_out, fixed_rate_clock;
    logic slow_osc_clock, crystal_clock_out, flexible_timer_clock_a, flexible_timer_clock_c;
    logic modulo_timer_clock, watchdog_clock, rtc_clock, adc_clock, clock_fail_reset, debug_link_clock;
    int fails, compares, g, n, r, cd, cnt[6];
    int exp_cnt[6] = '{50, 25, 50, 100, 100, 100};
    clock_gen u_clock_gen (.*, .loop_ref_clock(), .lock_irq());
    clock_partner u_clock_partner (.*);
    // ****************
    // tasks
    // ****************
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic wrap_up;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // apb transfer; holds the request until pready is sampled, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
        q = prdata;
        err_q = pslverr;
        if (k >= 20) begin fails++; wrap_up(); end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_main;
        g = 0;
        do begin @(posedge pclk); g++; end while (main_clock_out !== 1'b1 && g < 2000);
        if (g >= 2000) begin fails++; wrap_up(); end
    endtask
    function automatic int gap_exp(input int e);
        return 4 << e;
    endfunction
    // ****************
    // main sequence
    // ****************
    initial begin
        {psel, penable, pwrite, stop} <= 4'h0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        presetn <= 1'b0;
        void'($urandom(31));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 8'h00, 0); check("ctrl", 32'h0, q);
        apb(0, 8'h04, 0); check("trim", 32'h100, q);
        apb(0, 8'h0c, 0); check("clksel", 32'h0, q);
        apb(0, 8'h08, 0); check("src", 32'h0, q & 32'h18);
        apb(0, 8'h14, 0); check("unmapped", 32'h80000000, {err_q, q[30:0]});
        apb(1, 8'h10, 0); apb(0, 8'h10, 0); check("dco", 32'h1, 32'(q >= 52428));
        repeat (3) begin
            g = $urandom;
            apb(1, 8'h04, g); apb(0, 8'h04, 0); check("trim", g & 32'h1ff, q);
        end
        apb(1, 8'h00, 1); apb(1, 8'h00, 3); apb(0, 8'h00, 0); check("src3", 32'h1, q);
        $display("registers done");
        // every divider exponent in shuffled order, crystal source
        r = $urandom_range(0, 7);
        for (int i = 0; i < 8; i++) begin
            n = (i * 5 + r) & 7;
            apb(1, 8'h00, 2 | (n << 6));
            wait_main(); wait_main(); wait_main();
            check("gap", gap_exp(n), g);
        end
        $display("divider done");
        apb(1, 8'h0c, 32'h5aa);
        g = 0;
        do begin @(posedge pclk); g++; end while (!(crystal_tick && !timer_ext_clock_a) && g < 50);
        if (g >= 50) begin fails++; wrap_up(); end
        repeat (2) @(posedge pclk);
        repeat (400) begin
            @(posedge pclk);
            cnt[0] += flexible_timer_clock_a;
            cnt[1] += flexible_timer_clock_c;
            cnt[2] += modulo_timer_clock;
            cnt[3] += watchdog_clock;
            cnt[4] += rtc_clock;
            cnt[5] += adc_clock;
            cd += debug_link_clock;
        end
        foreach (cnt[i]) check("consumer", exp_cnt[i], cnt[i]);
        // 32 to 40 MHz over two against 20 MHz, one count lost to accumulator phase
        check("debug", 32'h1, 32'(cd >= 319 && cd <= 400));
        $display("consumers done");
        apb(1, 8'h00, 32'hc02);
        stop <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (clock_fail_reset !== 1'b1 && n < 2200);
        check("fail_time", 32'h1, 32'(n > 1980 && n < 2010));
        apb(0, 8'h08, 0); check("fail_flag", 32'h4, q & 32'h4);
        stop <= 1'b0;
        repeat (8) @(posedge pclk);
        check("fail_rst", 32'h0, {31'h0, clock_fail_reset});
        apb(1, 8'h08, 4); apb(0, 8'h08, 0); check("fail_w1c", 32'h0, q & 32'h4);
        $display("monitor done");
        wrap_up();
    end
endmodule
`default_nettype wire
